// *** imp_timing_core.v ***
// Summary of operation
// - Default four phases, starts spaced a quarter cycle in order one to four.
// - Phase four strapped high, phase three low: three phases, starts spaced a third cycle.
// - Phase three strapped high: two phases, starts spaced half a cycle.
// - Start spacing follows active count; each phase repeats once per switching period.
// - Duty capped 91.7% grounded, 75% floating, 83.3% high strap.
`timescale 1ns/1ps
`include "imp_defines.vh"

module imp_timing_core #(
	parameter DETECT_CYCLES = `IMP_DETECT_CYCLES
) (
	input  wire        mclk,
	input  wire        nrst,
	input  wire [15:0] slotCycles,
	input  wire        phaseOneDriveIn,
	output wire        phaseOneDriveOut,
	output wire        phaseOneDriveOen_n,
	input  wire        phaseTwoDriveIn,
	output wire        phaseTwoDriveOut,
	output wire        phaseTwoDriveOen_n,
	input  wire        phaseThreeDriveIn,
	output wire        phaseThreeDriveOut,
	output wire        phaseThreeDriveOen_n,
	input  wire        phaseFourDriveIn,
	output wire        phaseFourDriveOut,
	output wire        phaseFourDriveOen_n,
	input  wire        dutyLimitStrapHigh,
	input  wire        dutyLimitStrapLow,
	input  wire        outputPolaritySelect,
	input  wire [3:0]  phaseStop,
	output wire [2:0]  activePhases,
	output wire [1:0]  dutyLimitCode,
	output wire        running,
	output wire        latchedOff
);

	localparam [1:0]  ST_DETECT   = 2'h0;
	localparam [1:0]  ST_RUN      = 2'h1;
	localparam [1:0]  ST_OFF      = 2'h2;
	localparam integer DETECT_LAST_I = DETECT_CYCLES - 1;
	localparam [12:0]  DETECT_LAST   = DETECT_LAST_I[12:0];

	// ------------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------------
	// Straps, polarity and stop requests all come from pins
	reg  [10:0] pinMeta_q;
	reg  [10:0] pinSync_q;
	reg  [15:0] slotMeta_q;
	reg  [15:0] slotSync_q;
	wire [10:0] pinRaw;

	assign pinRaw = {phaseStop, outputPolaritySelect, dutyLimitStrapLow, dutyLimitStrapHigh,
		phaseFourDriveIn, phaseThreeDriveIn, phaseTwoDriveIn, phaseOneDriveIn};

	// Slot length is quasi-static; a change is seen cleanly only between slots
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pinMeta_q  <= 11'h000;
			pinSync_q  <= 11'h000;
			slotMeta_q <= `IMP_SLOT_CYCLES_RST;
			slotSync_q <= `IMP_SLOT_CYCLES_RST;
		end else begin
			pinMeta_q  <= pinRaw;
			pinSync_q  <= pinMeta_q;
			slotMeta_q <= slotCycles;
			slotSync_q <= slotMeta_q;
		end
	end

	wire       p1High   = pinSync_q[0];
	wire       p2High   = pinSync_q[1];
	wire       p3High   = pinSync_q[2];
	wire       p4High   = pinSync_q[3];
	wire       dutyHi   = pinSync_q[4];
	wire       dutyLo   = pinSync_q[5];
	wire       invert   = pinSync_q[6];
	wire [3:0] stopSync = pinSync_q[10:7];

	// ------------------------------------------------------------------------
	// Strap detection and run control
	// ------------------------------------------------------------------------
	reg [1:0]  state_q;
	reg [12:0] detCnt_q;
	reg [2:0]  phases_q;
	reg [1:0]  dutyCode_q;
	reg [3:0]  maxSlots_q;
	reg [3:0]  spacing_q;

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_q    <= ST_DETECT;
			detCnt_q   <= 13'h0000;
			phases_q   <= `IMP_PHASES_4;
			dutyCode_q <= `IMP_DUTY_CODE_FLOAT;
			maxSlots_q <= `IMP_DUTY_SLOTS_FLOAT;
			spacing_q  <= `IMP_SPACING_4PH;
		end else begin
			case (state_q)
			ST_DETECT: begin
				detCnt_q <= detCnt_q + 13'h0001;
				if (detCnt_q == DETECT_LAST) begin
					// A low phase strapped high is a wiring fault
					state_q <= (p1High || p2High) ? ST_OFF : ST_RUN;
					if (p3High) begin
						phases_q  <= `IMP_PHASES_2;
						spacing_q <= `IMP_SPACING_2PH;
					end else if (p4High) begin
						phases_q  <= `IMP_PHASES_3;
						spacing_q <= `IMP_SPACING_3PH;
					end else begin
						phases_q  <= `IMP_PHASES_4;
						spacing_q <= `IMP_SPACING_4PH;
					end
					if (dutyLo && !dutyHi) begin
						dutyCode_q <= `IMP_DUTY_CODE_GND;
						maxSlots_q <= `IMP_DUTY_SLOTS_GND;
					end else if (dutyHi && !dutyLo) begin
						dutyCode_q <= `IMP_DUTY_CODE_VCC;
						maxSlots_q <= `IMP_DUTY_SLOTS_VCC;
					end else begin
						dutyCode_q <= `IMP_DUTY_CODE_FLOAT;
						maxSlots_q <= `IMP_DUTY_SLOTS_FLOAT;
					end
				end
			end
			ST_RUN: begin
				state_q <= ST_RUN;
			end
			ST_OFF: begin
				// Held until nrst is asserted
				state_q <= ST_OFF;
			end
			default: begin
				state_q <= ST_OFF;
			end
			endcase
		end
	end

	wire run = (state_q == ST_RUN);

	// ------------------------------------------------------------------------
	// Switching time base
	// ------------------------------------------------------------------------
	reg  [15:0] tickCnt_q;
	reg  [3:0]  slot_q;
	wire        slotEnd;
	wire        slotTick;

	// A slot length of zero behaves as one cycle
	assign slotEnd  = ({1'b0, tickCnt_q} + 17'h00001) >= {1'b0, slotSync_q};
	assign slotTick = run && (tickCnt_q == 16'h0000);

	// twelve slots make one switching period
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			tickCnt_q <= 16'h0000;
			slot_q    <= 4'h0;
		end else if (!run) begin
			tickCnt_q <= 16'h0000;
			slot_q    <= 4'h0;
		end else if (slotEnd) begin
			tickCnt_q <= 16'h0000;
			slot_q    <= (slot_q == `IMP_SLOT_LAST) ? 4'h0 : slot_q + 4'h1;
		end else begin
			tickCnt_q <= tickCnt_q + 16'h0001;
		end
	end

	// ------------------------------------------------------------------------
	// Phase pulse generators
	// ------------------------------------------------------------------------
	wire [3:0] pulse;
	wire [3:0] phaseEn;
	reg  [3:0] driveOut_q;
	reg  [3:0] driveOen_q;

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gPhase
			localparam integer PHASE_NUM = g;
			wire [5:0]         startFull;
			assign startFull  = spacing_q * PHASE_NUM[1:0];
			assign phaseEn[g] = ({1'b0, PHASE_NUM[1:0]} < phases_q);

			imp_phase_gen uGen (
				.mclk      (mclk),
				.nrst      (nrst),
				.run       (run && phaseEn[g]),
				.slotTick  (slotTick),
				.slotNow   (slot_q),
				.startSlot (startFull[3:0]),
				.maxSlots  (maxSlots_q),
				.stopReq   (stopSync[g]),
				.pulse     (pulse[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Output stage
	// ------------------------------------------------------------------------
	// Pins stay released while straps are read, and after a latch-off so that
	// a strapped pin is never fought
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			driveOut_q <= 4'h0;
			driveOen_q <= 4'hf;
		end else begin
			// polarity applied
			// Normal sense is active low, as the drivers downstream invert
			driveOut_q <= ~(pulse ^ {4{invert}});
			driveOen_q <= ~(phaseEn & {4{run}});
		end
	end

	assign phaseOneDriveOut     = driveOut_q[0];
	assign phaseTwoDriveOut     = driveOut_q[1];
	assign phaseThreeDriveOut   = driveOut_q[2];
	assign phaseFourDriveOut    = driveOut_q[3];
	assign phaseOneDriveOen_n   = driveOen_q[0];
	assign phaseTwoDriveOen_n   = driveOen_q[1];
	assign phaseThreeDriveOen_n = driveOen_q[2];
	assign phaseFourDriveOen_n  = driveOen_q[3];
	assign activePhases         = phases_q;
	assign dutyLimitCode        = dutyCode_q;
	assign running              = run;
	assign latchedOff           = (state_q == ST_OFF);

endmodule // imp_timing_core

// *** imp_defines.vh ***
`ifndef IMP_DEFINES_VH
`define IMP_DEFINES_VH

// ----------------------------------------------------------------------------
// Switching cycle slots
// ----------------------------------------------------------------------------
// One switching cycle is cut into twelve equal slots
`define IMP_SLOTS_PER_CYCLE   4'hc
`define IMP_SLOT_LAST         4'hb

// Pulse-start spacing in slots: 1/4, 1/3, 1/2 of a cycle
`define IMP_SPACING_4PH       4'h3
`define IMP_SPACING_3PH       4'h4
`define IMP_SPACING_2PH       4'h6

// Duty limit in slots: 11/12 = 91.7 %, 9/12 = 75 %, 10/12 = 83.3 %
`define IMP_DUTY_SLOTS_GND    4'hb
`define IMP_DUTY_SLOTS_FLOAT  4'h9
`define IMP_DUTY_SLOTS_VCC    4'ha

// Duty strap code as reported
`define IMP_DUTY_CODE_GND     2'h0
`define IMP_DUTY_CODE_FLOAT   2'h1
`define IMP_DUTY_CODE_VCC     2'h2

// Active phase counts
`define IMP_PHASES_4          3'h4
`define IMP_PHASES_3          3'h3
`define IMP_PHASES_2          3'h2

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define IMP_MCLK_PERIOD_NS    5
`define IMP_DETECT_TIME_NS    30000
`define IMP_DETECT_CYCLES     ((`IMP_DETECT_TIME_NS + `IMP_MCLK_PERIOD_NS - 1) / `IMP_MCLK_PERIOD_NS)

// Reset values
`define IMP_SLOT_CYCLES_RST   16'h0001

`endif

// *** imp_phase_gen.v ***
`timescale 1ns/1ps
`include "imp_defines.vh"

module imp_phase_gen (
	input  wire       mclk,
	input  wire       nrst,
	input  wire       run,
	input  wire       slotTick,
	input  wire [3:0] slotNow,
	input  wire [3:0] startSlot,
	input  wire [3:0] maxSlots,
	input  wire       stopReq,
	output wire       pulse
);

	reg       on_q;
	reg [3:0] cnt_q;

	// ------------------------------------------------------------------------
	// Pulse state
	// ------------------------------------------------------------------------
	// Start wins over an early stop in the same cycle: a new cycle begins
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			on_q  <= 1'b0;
			cnt_q <= 4'h0;
		end else if (!run) begin
			on_q  <= 1'b0;
			cnt_q <= 4'h0;
		end else if (slotTick && slotNow == startSlot) begin
			on_q  <= 1'b1;
			cnt_q <= 4'h1;
		end else if (on_q && slotTick && cnt_q == maxSlots) begin
			on_q  <= 1'b0;
		end else if (on_q && stopReq) begin
			on_q  <= 1'b0;
		end else if (on_q && slotTick) begin
			cnt_q <= cnt_q + 4'h1;
		end
	end

	assign pulse = on_q;

endmodule // imp_phase_gen

// *** imp_timing_core_checker.sv ***
`timescale 1ns/1ps
module imp_timing_core_checker (
	input wire        mclk,
	input wire        nrst,
	input wire [15:0] slotCycles,
	input wire        phaseOneDriveOut,
	input wire        phaseOneDriveOen_n,
	input wire        phaseTwoDriveOut,
	input wire        phaseTwoDriveOen_n,
	input wire        phaseThreeDriveOen_n,
	input wire        phaseFourDriveOen_n,
	input wire        outputPolaritySelect,
	input wire [2:0]  activePhases,
	input wire [1:0]  dutyLimitCode,
	input wire        running,
	input wire        latchedOff
);
	// Polarity is only changed under reset, so the raw select undoes the inversion
	// Released pins count as idle, so strap levels never look like pulses
	wire        p1 = !phaseOneDriveOen_n && !(phaseOneDriveOut ^ outputPolaritySelect);
	wire        p2 = !phaseTwoDriveOen_n && !(phaseTwoDriveOut ^ outputPolaritySelect);
	wire [19:0] sc = {4'h0, slotCycles};
	wire [19:0] sp = (activePhases == 3'h4) ? 20'h3 : (activePhases == 3'h3) ? 20'h4 : 20'h6;
	wire [19:0] dl = (dutyLimitCode == 2'h0) ? 20'hb : (dutyLimitCode == 2'h2) ? 20'ha : 20'h9;
	reg  [19:0] gap_q;
	reg  [19:0] wid_q;
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			gap_q <= 20'h0;
			wid_q <= 20'h0;
		end else begin
			gap_q <= $rose(p1) ? 20'h1 : (gap_q != 20'h0) ? gap_q + 20'h1 : gap_q;
			wid_q <= p1 ? wid_q + 20'h1 : 20'h0;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	period_one_a: assert property (running && $rose(p1) && gap_q != 20'h0 |->
		gap_q == 20'hc * sc) else $error("phase period wrong");
	start_spacing_a: assert property (running && $rose(p2) && gap_q != 20'h0 |->
		gap_q == sp * sc) else $error("phase spacing wrong");
	duty_cap_a: assert property (running && $fell(p1) |-> wid_q == dl * sc)
		else $error("pulse width wrong");
	off_release_a: assert property (latchedOff |-> phaseOneDriveOen_n && phaseFourDriveOen_n && !running)
		else $error("off state drives");
	drive_start_a: assert property ($rose(running) |=> !phaseOneDriveOen_n)
		else $error("phase one not driven");
	three_hiz_a: assert property (activePhases != 3'h4 |-> phaseFourDriveOen_n)
		else $error("phase four driven");
	two_hiz_a: assert property (activePhases == 3'h2 |-> phaseThreeDriveOen_n)
		else $error("phase three driven");
	strap_hold_a: assert property (running |=> $stable(activePhases) && $stable(dutyLimitCode))
		else $error("straps changed in run");
	cover property (running && activePhases == 3'h3);
	cover property (running && activePhases == 3'h2);
	cover property (latchedOff);
	cover property (running && outputPolaritySelect && $rose(p1));
endmodule // imp_timing_core_checker
bind imp_timing_core imp_timing_core_checker imp_timing_core_checker_inst (.mclk(mclk),
	.nrst(nrst), .slotCycles(slotCycles), .phaseOneDriveOut(phaseOneDriveOut),
	.phaseOneDriveOen_n(phaseOneDriveOen_n), .phaseTwoDriveOut(phaseTwoDriveOut),
	.phaseTwoDriveOen_n(phaseTwoDriveOen_n),
	.phaseThreeDriveOen_n(phaseThreeDriveOen_n), .phaseFourDriveOen_n(phaseFourDriveOen_n),
	.outputPolaritySelect(outputPolaritySelect), .activePhases(activePhases),
	.dutyLimitCode(dutyLimitCode), .running(running), .latchedOff(latchedOff));

// *** imp_gate_model.sv ***
`timescale 1ns/1ps
module imp_gate_model (
	input  wire [3:0] pin,
	input  wire [3:0] pinOen_n,
	input  wire       invType,
	output wire [3:0] gate
);
	// Inverting drivers; a released pin keeps the gate off
	assign gate = ~pinOen_n & (pin ^ {4{invType}});
endmodule // imp_gate_model

// *** tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin nChecks = nChecks + 1; if ((a) !== (b)) begin nErrors = nErrors + 1; \
	$display("BAD %0t got %0d want %0d", $time, a, b); end end
module tb;
	reg        mclk = 1'b0;
	reg        nrst = 1'b0;
	reg  [3:0] strap = 4'h0;
	reg        dutyHi = 1'b0;
	reg        dutyLo = 1'b1;
	reg        pol = 1'b0;
	wire [3:0] out;
	wire [3:0] oen;
	wire [3:0] pin = (oen & strap) | (~oen & out);
	wire [3:0] gate;
	wire [2:0] activePhases;
	wire [1:0] dutyLimitCode;
	wire       running;
	wire       latchedOff;
	integer    nErrors = 0;
	integer    nChecks = 0;
	integer    cyc = 0;
	integer    g;
	integer    rise [0:3];
	integer    per [0:3];
	integer    wid [0:3];
	reg  [3:0] gPrev = 4'h0;
	always #2.5 mclk = ~mclk;
	// Short detection keeps each configuration near 126 cycles
	imp_timing_core #(.DETECT_CYCLES(8)) imp_timing_core_inst (.mclk(mclk), .nrst(nrst),
		.slotCycles(16'h0002), .phaseOneDriveIn(pin[0]), .phaseOneDriveOut(out[0]),
		.phaseOneDriveOen_n(oen[0]), .phaseTwoDriveIn(pin[1]), .phaseTwoDriveOut(out[1]),
		.phaseTwoDriveOen_n(oen[1]), .phaseThreeDriveIn(pin[2]), .phaseThreeDriveOut(out[2]),
		.phaseThreeDriveOen_n(oen[2]), .phaseFourDriveIn(pin[3]), .phaseFourDriveOut(out[3]),
		.phaseFourDriveOen_n(oen[3]), .dutyLimitStrapHigh(dutyHi), .dutyLimitStrapLow(dutyLo),
		.outputPolaritySelect(pol), .phaseStop(4'h0), .activePhases(activePhases),
		.dutyLimitCode(dutyLimitCode), .running(running), .latchedOff(latchedOff));
	imp_gate_model imp_gate_model_inst (.pin(pin), .pinOen_n(oen), .invType(~pol), .gate(gate));
	always @(posedge mclk) begin
		for (g = 0; g < 4; g = g + 1) begin
			if (gate[g] && !gPrev[g]) begin
				per[g] = cyc - rise[g];
				rise[g] = cyc;
			end
			if (!gate[g] && gPrev[g])
				wid[g] = cyc - rise[g];
		end
		gPrev <= gate;
		cyc = cyc + 1;
	end
	task print_verdict;
		begin
			$display("checks %0d errors %0d", nChecks, nErrors);
			if (nErrors == 0 && nChecks > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	task run_cfg(input [3:0] s, input hi, input lo, input p, input [2:0] nph,
		input [1:0] code, input integer slots, input integer sp);
		integer k;
		begin
			@(posedge mclk);
			nrst <= 1'b0;
			strap <= s;
			dutyHi <= hi;
			dutyLo <= lo;
			pol <= p;
			repeat (5) @(posedge mclk);
			nrst <= 1'b1;
			repeat (120) @(posedge mclk);
			@(negedge mclk);
			`CHK(activePhases, nph)
			`CHK(dutyLimitCode, code)
			`CHK(latchedOff, s[0] | s[1])
			`CHK(running, !(s[0] | s[1]))
			for (k = 0; k < 4; k = k + 1) begin
				if (k < nph && !s[0]) begin
					`CHK(per[k], 24)
					`CHK(wid[k], slots * 2)
					`CHK((rise[k] - rise[0] + 240) % 24, (k * sp * 2) % 24)
				end else
					`CHK(oen[k], 1'b1)
			end
		end
	endtask
	initial begin
		repeat (2000) @(posedge mclk);
		nErrors = nErrors + 1;
		print_verdict;
	end
	initial begin
		for (g = 0; g < 4; g = g + 1)
			rise[g] = 0;
		run_cfg(4'h0, 1'b0, 1'b1, 1'b0, 3'h4, 2'h0, 11, 3);
		run_cfg(4'h8, 1'b0, 1'b0, 1'b1, 3'h3, 2'h1, 9, 4);
		run_cfg(4'hc, 1'b1, 1'b0, 1'b0, 3'h2, 2'h2, 10, 6);
		run_cfg(4'h4, 1'b1, 1'b1, 1'b1, 3'h2, 2'h1, 9, 6);
		run_cfg(4'h1, 1'b0, 1'b1, 1'b0, 3'h4, 2'h0, 11, 3);
		print_verdict;
	end
endmodule // tb
